// file: logic/can_buf_pkg.sv
// shared constants for the message buffer word 2 / word 3 register block
// assumes one 50 MHz core clock and a plain single-cycle register port
package can_buf_pkg;

  // ****************************************
  // register map (word index on the port)
  // ****************************************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [3:0] OFS_WORD2 = 4'h0;
  localparam logic [3:0] OFS_WORD3 = 4'h1;
  localparam logic [3:0] OFS_CTRL = 4'h2;
  localparam logic [3:0] OFS_STATUS = 4'h3;

  // ****************************************
  // word 2 field layout
  // ****************************************
  localparam int EID_LSB = 10;
  localparam int EID_MSB = 15;
  localparam int RTR_BIT = 9;
  localparam int RSV_UPPER_BIT = 8;
  localparam int UNUSED_MSB = 7;
  localparam int UNUSED_LSB = 5;
  localparam int RSV_LOWER_BIT = 4;
  localparam int DLC_MSB = 3;
  localparam int DLC_LSB = 0;
  localparam logic [15:0] WORD2_WR_MASK = 16'hff1f;

  // ****************************************
  // word 3 byte lanes
  // ****************************************
  localparam int BYTE1_LSB = 8;
  localparam int BYTE0_LSB = 0;

  // ****************************************
  // control and status bit positions
  // ****************************************
  localparam int CTRL_IDE_BIT = 0;
  localparam int STAT_REMOTE_BIT = 0;
  localparam int STAT_RX_NEW_BIT = 1;
  localparam int STAT_RSV_ERR_BIT = 2;
  localparam int STAT_LEN_LSB = 4;

  // ****************************************
  // values after reset and limits
  // ****************************************
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic CTRL_IDE_RESET = 1'b0;
  localparam logic [3:0] MAX_DATA_BYTES = 4'h8;

endpackage

// file: logic/can_msg_buffer_word_layout.sv
// message buffer words 2 and 3: software port, receive load, transmit fields
// assumes rx_* inputs come from the protocol engine on core_clk
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ps

// What this block does
// - the remote request flag is taken from bit 9 of buffer word 2.
// - on an extended frame a remote flag of 1 makes a remote request and 0 a data frame.
// - on a standard frame the remote flag in word 2 is ignored.
// - bits 3 to 0 of word 2 are the data length code of the message.
// - word 3 holds data byte 1 in bits 15 to 8 and data byte 0 in bits 7 to 0.
module can_msg_buffer_word_layout
  import can_buf_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic rx_load,
  input wire logic rx_ide,
  input wire logic [5:0] rx_extended_id_low_bits,
  input wire logic rx_rtr,
  input wire logic [3:0] rx_dlc,
  input wire logic [7:0] rx_byte0,
  input wire logic [7:0] rx_byte1,
  output logic tx_ide,
  output logic [5:0] tx_extended_id_low_bits,
  output logic tx_remote_req,
  output logic [3:0] tx_dlc,
  output logic [3:0] tx_data_len,
  output logic [7:0] tx_byte0,
  output logic [7:0] tx_byte1,
  output logic tx_rsv_err
);

  // ****************************************
  // storage and decode
  // ****************************************
  logic [15:0] word2_ff;
  logic [15:0] word3_ff;
  logic ide_ff;
  logic rx_new_ff;
  logic past_valid_ff;
  logic [15:0] nxt_rdata;
  logic [15:0] rx_word2;
  logic [15:0] rx_word3;
  logic [15:0] status_word;
  logic wr_word2;
  logic wr_word3;
  logic wr_ctrl;
  logic wr_status;
  logic [5:0] dec_eid;
  logic dec_rtr_raw;
  logic dec_remote;
  logic dec_rsv;
  logic [3:0] dec_dlc;
  logic [3:0] dec_len;
  logic [7:0] dec_byte0;
  logic [7:0] dec_byte1;

  can_word2_fields u_word2 (
    .word(word2_ff),
    .ide(ide_ff),
    .extended_id_low_bits(dec_eid),
    .rtr_raw(dec_rtr_raw),
    .remote_req(dec_remote),
    .rsv_nonzero(dec_rsv),
    .dlc(dec_dlc),
    .data_len(dec_len)
  );

  can_word3_bytes u_word3 (
    .word(word3_ff),
    .in_byte0(rx_byte0),
    .in_byte1(rx_byte1),
    .byte0(dec_byte0),
    .byte1(dec_byte1),
    .packed_word(rx_word3)
  );

  // ****************************************
  // write decode
  // ****************************************
  // strobes are one cycle, so each write lands once, unless an rx_load in the same cycle overrides it
  always_comb begin
    wr_word2 = reg_wr && (reg_addr == OFS_WORD2);
    wr_word3 = reg_wr && (reg_addr == OFS_WORD3);
    wr_ctrl = reg_wr && (reg_addr == OFS_CTRL);
    wr_status = reg_wr && (reg_addr == OFS_STATUS);
  end

  // received frame packed into word 2; reserved and unused bits forced low
  always_comb begin
    rx_word2 = WORD_RESET;
    rx_word2[EID_MSB:EID_LSB] = rx_extended_id_low_bits;
    rx_word2[RTR_BIT] = rx_rtr;
    rx_word2[DLC_MSB:DLC_LSB] = rx_dlc;
  end

  // ****************************************
  // buffer word 2
  // ****************************************
  // a received frame wins over a software write in the same cycle,
  // losing a frame is worse than losing a racing store
  always_ff @(posedge core_clk) begin
    if (rst) begin
      word2_ff <= WORD_RESET;
    end else if (rx_load) begin
      word2_ff <= rx_word2;
    end else if (wr_word2) begin
      word2_ff <= reg_wdata & WORD2_WR_MASK;
    end
  end

  // ****************************************
  // buffer word 3
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      word3_ff <= WORD_RESET;
    end else if (rx_load) begin
      word3_ff <= rx_word3;
    end else if (wr_word3) begin
      word3_ff <= reg_wdata;
    end
  end

  // ****************************************
  // frame format flag
  // ****************************************
  // the extension flag lives in word 1, outside this block, so it is held here
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ide_ff <= CTRL_IDE_RESET;
    end else if (rx_load) begin
      ide_ff <= rx_ide;
    end else if (wr_ctrl) begin
      ide_ff <= reg_wdata[CTRL_IDE_BIT];
    end
  end

  // ****************************************
  // new frame flag
  // ****************************************
  // write one to clear; a load in the same cycle keeps it set
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_new_ff <= 1'b0;
    end else if (rx_load) begin
      rx_new_ff <= 1'b1;
    end else if (wr_status && reg_wdata[STAT_RX_NEW_BIT]) begin
      rx_new_ff <= 1'b0;
    end
  end

  // ****************************************
  // read path
  // ****************************************
  always_comb begin
    status_word = WORD_RESET;
    status_word[STAT_REMOTE_BIT] = dec_remote;
    status_word[STAT_RX_NEW_BIT] = rx_new_ff;
    status_word[STAT_RSV_ERR_BIT] = dec_rsv;
    status_word[STAT_LEN_LSB +: 4] = dec_len;
  end

  // unmapped addresses read zero; data only stands in the cycle after the strobe
  always_comb begin
    nxt_rdata = WORD_RESET;
    if (reg_rd) begin
      case (reg_addr)
        OFS_WORD2: begin
          nxt_rdata = word2_ff & WORD2_WR_MASK;
        end
        OFS_WORD3: begin
          nxt_rdata = word3_ff;
        end
        OFS_CTRL: begin
          nxt_rdata[CTRL_IDE_BIT] = ide_ff;
        end
        OFS_STATUS: begin
          nxt_rdata = status_word;
        end
        default: begin
          nxt_rdata = WORD_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= WORD_RESET;
    end else begin
      reg_rdata <= nxt_rdata;
    end
  end

  // ****************************************
  // fields toward the protocol engine
  // ****************************************
  // registered so the engine sees one consistent snapshot per cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_ide <= CTRL_IDE_RESET;
      tx_extended_id_low_bits <= 6'h00;
      tx_remote_req <= 1'b0;
      tx_dlc <= 4'h0;
      tx_data_len <= 4'h0;
    end else begin
      tx_ide <= ide_ff;
      tx_extended_id_low_bits <= dec_eid;
      tx_remote_req <= dec_remote;
      tx_dlc <= dec_dlc;
      tx_data_len <= dec_len;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_byte0 <= 8'h00;
      tx_byte1 <= 8'h00;
    end else begin
      tx_byte0 <= dec_byte0;
      tx_byte1 <= dec_byte1;
    end
  end

  // nonzero reserved bits would put a malformed frame on the bus
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_rsv_err <= 1'b0;
    end else begin
      tx_rsv_err <= dec_rsv;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      past_valid_ff <= 1'b0;
    end else begin
      past_valid_ff <= 1'b1;
    end
  end

  a_remote_from_bit9: assert property (
    @(posedge core_clk) disable iff (rst)
    (past_valid_ff && ide_ff && word2_ff[RTR_BIT]) |=> tx_remote_req
  ) else $error("remote request not taken from word 2 bit 9");

  a_extended_data_frame: assert property (
    @(posedge core_clk) disable iff (rst)
    (wr_word2 && !rx_load && reg_wdata[RTR_BIT] == 1'b0 && ide_ff && !wr_ctrl)
      |=> ##1 !tx_remote_req
  ) else $error("extended frame with flag 0 became a remote request");

  a_standard_ignores_rtr: assert property (
    @(posedge core_clk) disable iff (rst)
    (past_valid_ff && !ide_ff) |=> !tx_remote_req
  ) else $error("standard frame produced a remote request");

  a_dlc_field_path: assert property (
    @(posedge core_clk) disable iff (rst)
    (wr_word2 && !rx_load) |=> ##1 (tx_dlc == $past(reg_wdata[3:0], 2))
  ) else $error("data length code not taken from word 2 bits 3 to 0");

  a_byte_lanes_order: assert property (
    @(posedge core_clk) disable iff (rst)
    (wr_word3 && !rx_load) |=> ##1
      (tx_byte1 == $past(reg_wdata[15:8], 2) && tx_byte0 == $past(reg_wdata[7:0], 2))
  ) else $error("word 3 byte lanes swapped or stale");

  a_unused_read_zero: assert property (
    @(posedge core_clk) disable iff (rst)
    (reg_rd && reg_addr == OFS_WORD2) |=> (reg_rdata[7:5] == 3'h0)
  ) else $error("word 2 bits 7 to 5 did not read zero");

  a_eid_low_path: assert property (
    @(posedge core_clk) disable iff (rst)
    rx_load |=> ##1 (tx_extended_id_low_bits == $past(rx_extended_id_low_bits, 2))
  ) else $error("low extended id bits not carried from word 2 bits 15 to 10");

  // a raw remote flag on a standard frame must never reach the engine
  a_standard_raw_flag: assert property (
    @(posedge core_clk) disable iff (rst)
    (past_valid_ff && dec_rtr_raw && !ide_ff) |=> !tx_remote_req
  ) else $error("raw remote flag leaked on a standard frame");

  // software left a reserved bit set, so the engine must be warned
  a_rsv_flag_raise: assert property (
    @(posedge core_clk) disable iff (rst)
    (past_valid_ff && (word2_ff[RSV_UPPER_BIT] || word2_ff[RSV_LOWER_BIT])) |=> tx_rsv_err
  ) else $error("nonzero reserved bit in word 2 not flagged");

endmodule

// file: logic/can_word2_fields.sv
// splits buffer word 2 into the fields the protocol engine uses
// assumes the caller registers the outputs; pure combinational
`timescale 1ns/1ps
module can_word2_fields
  import can_buf_pkg::*;
(
  input wire logic [15:0] word,
  input wire logic ide,
  output logic [5:0] extended_id_low_bits,
  output logic rtr_raw,
  output logic remote_req,
  output logic rsv_nonzero,
  output logic [3:0] dlc,
  output logic [3:0] data_len
);

  // ****************************************
  // field extraction
  // ****************************************
  // remote request only means something for extended frames
  always_comb begin
    extended_id_low_bits = word[EID_MSB:EID_LSB];
    rtr_raw = word[RTR_BIT];
    remote_req = ide & word[RTR_BIT];
    rsv_nonzero = word[RSV_UPPER_BIT] | word[RSV_LOWER_BIT];
    dlc = word[DLC_MSB:DLC_LSB];
    // codes above eight still carry eight data bytes
    data_len = (word[DLC_MSB:DLC_LSB] > MAX_DATA_BYTES) ? MAX_DATA_BYTES :
      word[DLC_MSB:DLC_LSB];
  end

endmodule

// file: logic/can_word3_bytes.sv
// splits buffer word 3 into data bytes and packs received bytes back
// assumes byte 0 is the first byte on the wire
`timescale 1ns/1ps
module can_word3_bytes
  import can_buf_pkg::*;
(
  input wire logic [15:0] word,
  input wire logic [7:0] in_byte0,
  input wire logic [7:0] in_byte1,
  output logic [7:0] byte0,
  output logic [7:0] byte1,
  output logic [15:0] packed_word
);

  // ****************************************
  // byte lanes
  // ****************************************
  // byte 1 high, byte 0 low
  always_comb begin
    byte0 = word[BYTE0_LSB +: 8];
    byte1 = word[BYTE1_LSB +: 8];
    packed_word = {in_byte1, in_byte0};
  end

endmodule

// file: test/can_engine_model.sv
// protocol engine stand-in that hands received frame fields to the buffer
// assumes one core_clk domain and a one-cycle send request from the bench
`timescale 1ns/1ps
module can_engine_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic send,
  input wire logic [1:0] lag,
  input wire logic f_ide,
  input wire logic [5:0] f_eid,
  input wire logic f_rtr,
  input wire logic [3:0] f_dlc,
  input wire logic [7:0] f_b0,
  input wire logic [7:0] f_b1,
  output logic rx_load,
  output logic rx_ide,
  output logic [5:0] rx_extended_id_low_bits,
  output logic rx_rtr,
  output logic [3:0] rx_dlc,
  output logic [7:0] rx_byte0,
  output logic [7:0] rx_byte1
);
  logic pend_ff;
  logic [1:0] wait_ff;
  logic fire;

  assign fire = pend_ff && (wait_ff == 2'h0);

  // delivery timing: lag gives prompt or slow answers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pend_ff <= 1'b0;
      wait_ff <= 2'h0;
      rx_load <= 1'b0;
    end else if (send) begin
      pend_ff <= 1'b1;
      wait_ff <= lag;
      rx_load <= 1'b0;
    end else begin
      rx_load <= fire;
      pend_ff <= pend_ff && !fire;
      wait_ff <= fire ? 2'h0 : wait_ff - {1'b0, pend_ff};
    end
  end

  // fields valid only with the load pulse; inverted after so stale data is not seen
  // the frame carries no reserved bits, so the buffer gets zeros there
  always_ff @(posedge core_clk) begin
    if (rst) begin
      {rx_ide, rx_extended_id_low_bits, rx_rtr, rx_dlc, rx_byte0, rx_byte1} <= '0;
    end else if (fire) begin
      {rx_ide, rx_extended_id_low_bits, rx_rtr, rx_dlc, rx_byte0, rx_byte1} <=
        {f_ide, f_eid, f_rtr, f_dlc, f_b0, f_b1};
    end else if (rx_load) begin
      {rx_ide, rx_extended_id_low_bits, rx_rtr, rx_dlc, rx_byte0, rx_byte1} <=
        ~{rx_ide, rx_extended_id_low_bits, rx_rtr, rx_dlc, rx_byte0, rx_byte1};
    end
  end
endmodule

// file: test/test_can_msg_buffer_word_layout.sv
// self-checking bench for the message buffer word 2 / word 3 block
// assumes the register port answers reads one cycle later and never stalls
`timescale 1ns/1ps
module test_can_msg_buffer_word_layout;
  import can_buf_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic rx_load, rx_ide, rx_rtr;
  logic [5:0] rx_eid;
  logic [3:0] rx_dlc;
  logic [7:0] rx_byte0, rx_byte1;
  logic tx_ide, tx_remote_req, tx_rsv_err;
  logic [5:0] tx_eid;
  logic [3:0] tx_dlc, tx_data_len;
  logic [7:0] tx_byte0, tx_byte1;
  logic m_send = 1'b0;
  logic [1:0] m_lag = 2'h0;
  logic [23:0] m_f = 24'h000000;
  logic [3:0] m_dlc = 4'h0;
  int n_mismatch = 0;
  int samples_checked = 0;

  always #10 core_clk = ~core_clk;

  can_msg_buffer_word_layout dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_load(rx_load), .rx_ide(rx_ide), .rx_extended_id_low_bits(rx_eid), .rx_rtr(rx_rtr),
    .rx_dlc(rx_dlc), .rx_byte0(rx_byte0), .rx_byte1(rx_byte1), .tx_ide(tx_ide),
    .tx_extended_id_low_bits(tx_eid), .tx_remote_req(tx_remote_req), .tx_dlc(tx_dlc),
    .tx_data_len(tx_data_len), .tx_byte0(tx_byte0), .tx_byte1(tx_byte1),
    .tx_rsv_err(tx_rsv_err));

  can_engine_model engine (.core_clk(core_clk), .rst(rst), .send(m_send), .lag(m_lag),
    .f_ide(m_f[23]), .f_eid(m_f[22:17]), .f_rtr(m_f[16]), .f_dlc(m_dlc), .f_b0(m_f[7:0]),
    .f_b1(m_f[15:8]), .rx_load(rx_load), .rx_ide(rx_ide), .rx_extended_id_low_bits(rx_eid),
    .rx_rtr(rx_rtr), .rx_dlc(rx_dlc), .rx_byte0(rx_byte0), .rx_byte1(rx_byte1));

  // ****************************************
  // shared bus and compare tasks
  // ****************************************
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, then drop to zero
  task automatic chk_rd(input string what, input logic [3:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    cmp(what, exp, reg_rdata);
    @(posedge core_clk);
    #1;
    cmp("rdata after", 16'h0000, reg_rdata);
  endtask

  // tx outputs follow a write two edges after it
  task automatic settle();
    @(posedge core_clk);
    #1;
  endtask

  task automatic send_frame(input logic [1:0] lag, input logic [23:0] f, input logic [3:0] d);
    bit seen;
    @(posedge core_clk);
    m_send <= 1'b1;
    m_lag <= lag;
    m_f <= f;
    m_dlc <= d;
    @(posedge core_clk);
    m_send <= 1'b0;
    seen = 0;
    for (int k = 0; k < 8 && !seen; k++) begin
      @(posedge core_clk);
      #1;
      seen = (rx_load === 1'b1);
    end
    if (!seen) begin
      n_mismatch++;
      $display("[ERR] rx_load expected 1 seen 0");
      conclude();
    end
    @(posedge core_clk);
    settle();
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    chk_rd("word2", OFS_WORD2, WORD_RESET);
    chk_rd("word3", OFS_WORD3, WORD_RESET);
    chk_rd("status", OFS_STATUS, 16'h0000);
  endtask

  // unused bits 7:5 written as ones, standard format first
  task automatic t_word2();
    wr(OFS_WORD2, 16'hfee5);
    settle();
    cmp("eid", 16'h003f, {10'h000, tx_eid});
    cmp("dlc", 16'h0005, {12'h000, tx_dlc});
    cmp("remote std", 16'h0000, {15'h0000, tx_remote_req});
    chk_rd("word2 rb", OFS_WORD2, 16'hfe05);
    wr(OFS_CTRL, 16'h0001);
    settle();
    cmp("remote ext", 16'h0001, {15'h0000, tx_remote_req});
    wr(OFS_WORD2, 16'h0405);
    settle();
    cmp("data ext", 16'h0000, {15'h0000, tx_remote_req});
  endtask

  // every length code, including the ones above eight
  task automatic t_dlc();
    for (int i = 0; i < 16; i++) begin
      wr(OFS_WORD2, {12'h000, 4'(i)});
      settle();
      cmp("dlc", 16'(i), {12'h000, tx_dlc});
      cmp("len", (i > 8) ? 16'h0008 : 16'(i), {12'h000, tx_data_len});
    end
  endtask

  task automatic t_word3();
    wr(OFS_WORD3, 16'ha55a);
    settle();
    cmp("byte1", 16'h00a5, {8'h00, tx_byte1});
    cmp("byte0", 16'h005a, {8'h00, tx_byte0});
    chk_rd("word3 rb", OFS_WORD3, 16'ha55a);
  endtask

  // reserved bits written nonzero on purpose, then cleared as software must
  task automatic t_rsv_unmapped();
    wr(OFS_WORD2, 16'h0100);
    settle();
    cmp("rsv upper", 16'h0001, {15'h0000, tx_rsv_err});
    wr(OFS_WORD2, 16'h0010);
    settle();
    cmp("rsv lower", 16'h0001, {15'h0000, tx_rsv_err});
    wr(OFS_WORD2, 16'h0000);
    wr(4'hf, 16'hffff);
    chk_rd("unmapped", 4'hf, 16'h0000);
    cmp("rsv clear", 16'h0000, {15'h0000, tx_rsv_err});
  endtask

  // extended remote frame with slow delivery, then a prompt standard one
  task automatic t_rx();
    send_frame(2'h2, {1'b1, 6'h2a, 1'b1, 16'h2211}, 4'h8);
    cmp("rx remote", 16'h0001, {15'h0000, tx_remote_req});
    cmp("rx ide", 16'h0001, {15'h0000, tx_ide});
    cmp("rx byte0", 16'h0011, {8'h00, tx_byte0});
    chk_rd("rx word2", OFS_WORD2, 16'haa08);
    chk_rd("rx status", OFS_STATUS, 16'h0083);
    wr(OFS_STATUS, 16'h0002);
    chk_rd("status cleared", OFS_STATUS, 16'h0081);
    send_frame(2'h0, {1'b0, 6'h15, 1'b1, 16'h4433}, 4'h3);
    cmp("rx std", 16'h0000, {15'h0000, tx_remote_req});
    cmp("rx ide std", 16'h0000, {15'h0000, tx_ide});
    chk_rd("rx ctrl", OFS_CTRL, 16'h0000);
    chk_rd("rx status std", OFS_STATUS, 16'h0032);
    cmp("rx dlc", 16'h0003, {12'h000, tx_dlc});
    cmp("rx word3", 16'h4433, {tx_byte1, tx_byte0});
  endtask

  task automatic conclude();
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #1000000;
    n_mismatch++;
    $display("[ERR] run time expected short seen limit");
    conclude();
  end

  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_word2();
    t_dlc();
    t_word3();
    t_rsv_unmapped();
    t_rx();
    conclude();
  end
endmodule
